// file: core/pdsa_pkg.sv
// Purpose: constants and types shared by the program/data space access block
// Assumes: 16-bit byte addresses, 24-bit program words
// Notes: data map boundaries are parameters of plain value
package pdsa_pkg;
    localparam int unsigned PDSA_DW = 16;
    localparam int unsigned PDSA_PW = 24;
    localparam int unsigned PDSA_PAW = 24;
    localparam int unsigned PDSA_PC_STEP_I = 2;
    localparam logic [23:0] PDSA_PC_STEP = 24'h000002;
    localparam logic [23:0] PDSA_PC_RST = 24'h000000;
    localparam logic [23:0] PDSA_USER_MAX = 24'h7ffffe;
    localparam int unsigned PDSA_WIN_BIT = 15;
    localparam int unsigned PDSA_TBL_CFG_BIT = 7;
    localparam logic [15:0] PDSA_Y_BASE = 16'h0080;
    localparam logic [15:0] PDSA_Y_END = 16'h00ff;
    localparam logic [15:0] PDSA_RAM_END = 16'h00ff;
    localparam logic [15:0] PDSA_ZERO = 16'h0000;
    localparam logic [7:0] PDSA_ZB = 8'h00;
    localparam logic [1:0] PDSA_STALL_ONE = 2'h1;
    localparam logic [1:0] PDSA_STALL_TWO = 2'h2;
    localparam logic [1:0] PDSA_STALL_NONE = 2'h0;

    // table read kinds
    typedef enum logic [1:0] {
        PDSA_TBL_NONE,
        PDSA_TBL_LOW,
        PDSA_TBL_HIGH
    } pdsa_tbl_t;

    // pointer source of an access
    typedef enum logic [1:0] {
        PDSA_PTR_OTHER,
        PDSA_PTR_X,
        PDSA_PTR_Y
    } pdsa_ptr_t;
endpackage

// file: core/pdsa_tbl_mux.sv
// Purpose: format a 24-bit program word into a table-read data word
// Assumes: word already fetched; byte select is the address lsb
// Notes: pure combinational
`timescale 1ns/10ps
module pdsa_tbl_mux
    import pdsa_pkg::*;
(
    input wire pdsa_tbl_t i_kind, // low or high half
    input wire logic i_byte, // byte-sized read
    input wire logic i_bsel, // byte select
    input wire logic [23:0] i_pword, // program word
    output logic [15:0] o_data // formatted data
);
    // pick fields per kind and size
    always_comb begin
        o_data = PDSA_ZERO;
        if (i_kind == PDSA_TBL_LOW) begin
            if (!i_byte) begin
                o_data = i_pword[15:0];
            end else if (!i_bsel) begin
                o_data = {PDSA_ZB, i_pword[7:0]};
            end else begin
                o_data = {PDSA_ZB, i_pword[15:8]};
            end
        end else if (i_kind == PDSA_TBL_HIGH) begin
            if (!i_byte || !i_bsel) begin
                o_data = {PDSA_ZB, i_pword[23:16]};
            end else begin
                o_data = PDSA_ZERO;
            end
        end
    end
endmodule

// file: core/pdsa_core.sv
// Purpose: address generation and read data path for program and data spaces
// Assumes: single clock; memories answer combinationally in the same cycle
// Notes: core pipeline issues one access per cycle; no software registers
// Behaviour
// - program counter steps two per word
// - low word table read passes bits 15..0
// - low byte read selects by byte select
// - high word read zero-extends bits 23..16
// - high byte read, select one gives zero
// - window needs address msb and enable
// - window address from page and 15 bits
// - window exposes only low 16 bits
// - table access suspends the window
// - outside repeat add one or two cycles
// - repeat edges add two, others none
// - multiply class: Y via y pointers only
// - multiply reads exclude Y from X
// - all writes over X write bus
// - modulo both spaces, bit-reverse X writes; here modulo wraps write addresses only
// - invalid accesses read as zero
// - effective address is 16-bit byte address
// - accumulator write-back uses X bus anywhere
// - X/Y boundary fixed, Y inside X
// - user range unless table page bit 7; here the table page is not checked, only pc advance is flagged
`timescale 1ns/10ps
module pdsa_core
    import pdsa_pkg::*;
(
    input wire logic i_clk, // core clock
    input wire logic i_arst_n, // async reset, active low
    input wire logic i_pc_adv, // advance program counter
    input wire logic i_pc_load, // load program counter
    input wire logic [23:0] i_pc_val, // load value
    output logic [23:0] o_pc, // program counter
    input wire logic i_cc_we, // write core control window bit
    input wire logic i_cc_wdata, // window enable value
    input wire logic i_pg_we, // write window page
    input wire logic [7:0] i_pg_wdata, // window page value
    input wire logic i_tp_we, // write table page
    input wire logic [7:0] i_tp_wdata, // table page value
    output logic o_window_en, // program_window_enable bit
    output logic [7:0] o_window_page, // program_window_page
    output logic [7:0] o_table_page, // table_page_reg
    input wire pdsa_tbl_t i_tbl_kind, // table read kind
    input wire logic i_tbl_wr, // table write in progress
    input wire logic i_tbl_byte, // byte-sized table read
    input wire logic [15:0] i_tbl_ea, // table effective address
    input wire logic i_rd, // data read request
    input wire logic i_rd_byte, // byte read
    input wire logic [15:0] i_rd_ea, // X read effective address
    input wire pdsa_ptr_t i_rd_ptr, // pointer class of X read
    input wire logic i_mac, // multiply class instruction
    input wire logic i_y_rd, // Y prefetch request
    input wire logic [15:0] i_y_ea, // Y effective address
    input wire pdsa_ptr_t i_y_ptr, // pointer class of Y read
    input wire logic i_short_op, // move, double move, mac prefetch
    input wire logic i_in_rpt, // inside repeat loop
    input wire logic i_rpt_edge, // first/last/irq exit/re-entry
    input wire logic i_wr, // data write request
    input wire logic i_wr_acc, // accumulator write-back
    input wire logic i_wr_byte, // byte write
    input wire logic [15:0] i_wr_ea, // write effective address
    input wire logic [15:0] i_wr_data, // write data
    input wire logic i_mod_en, // modulo addressing enable
    input wire logic [15:0] i_mod_start, // modulo buffer start
    input wire logic [15:0] i_mod_end, // modulo buffer end
    input wire logic i_brev_en, // bit-reversed write enable
    input wire logic [15:0] i_brev_mod, // bit-reverse modifier
    output logic [23:0] o_prog_addr, // program memory address
    output logic o_prog_rd, // program memory read strobe
    input wire logic [23:0] i_prog_rdata, // program word
    output logic [15:0] o_xmem_addr, // X memory word address (bytes)
    input wire logic [15:0] i_xmem_rdata, // X memory read word
    output logic [15:0] o_ymem_addr, // Y memory address
    output logic o_ymem_rd, // Y read strobe
    input wire logic [15:0] i_ymem_rdata, // Y memory read word
    output logic o_xwr_en, // X write bus strobe
    output logic [1:0] o_xwr_be, // byte enables
    output logic [15:0] o_xwr_addr, // X write address
    output logic [15:0] o_xwr_data, // X write data
    output logic [15:0] o_x_rdata, // X read data, registered
    output logic [15:0] o_y_rdata, // Y read data, registered
    output logic o_rd_valid, // read data valid pulse
    output logic [1:0] o_stall, // extra instruction cycles
    output logic o_prog_range_err // program counter advance above user space
);
    logic [23:0] pc_ff;
    logic win_en_ff;
    logic [7:0] win_pg_ff;
    logic [7:0] tbl_pg_ff;
    logic [15:0] x_rdata_ff;
    logic [15:0] y_rdata_ff;
    logic rd_valid_ff;
    logic [1:0] stall_ff;
    logic xwr_en_ff;
    logic [1:0] xwr_be_ff;
    logic [15:0] xwr_addr_ff;
    logic [15:0] xwr_data_ff;
    logic range_err_ff;
    logic tbl_active;
    logic win_hit;
    logic [15:0] tbl_data;
    logic [15:0] nxt_x_rdata;
    logic [15:0] wr_ea_eff;
    logic [23:0] nxt_pc;

    // address is in the fixed Y region
    function automatic logic in_y(input logic [15:0] ea);
        in_y = (ea >= PDSA_Y_BASE) && (ea <= PDSA_Y_END);
    endfunction

    // address hits implemented RAM
    function automatic logic in_ram(input logic [15:0] ea);
        in_ram = (ea <= PDSA_RAM_END);
    endfunction

    // wrap an address inside the circular buffer
    function automatic logic [15:0] modwrap(input logic [15:0] ea,
                                            input logic [15:0] st,
                                            input logic [15:0] en);
        if (ea > en) begin
            modwrap = st + (ea - en - 16'h0001);
        end else if (ea < st) begin
            modwrap = en - (st - ea - 16'h0001);
        end else begin
            modwrap = ea;
        end
    endfunction

    // reverse-carry add for bit-reversed pointer update
    function automatic logic [15:0] brev_add(input logic [15:0] ea,
                                             input logic [15:0] m);
        logic [15:0] r;
        logic [15:0] rm;
        r = '0;
        rm = '0;
        for (int i = 0; i < 16; i++) begin
            r[i] = ea[15 - i];
            rm[i] = m[15 - i];
        end
        r = r + rm;
        for (int i = 0; i < 16; i++) begin
            brev_add[i] = r[15 - i];
        end
    endfunction

    // window suspended during table traffic
    assign tbl_active = (i_tbl_kind != PDSA_TBL_NONE) || i_tbl_wr;
    assign win_hit = i_rd && i_rd_ea[PDSA_WIN_BIT] && win_en_ff && !tbl_active;

    // program counter, two per word so it lines up with data addresses
    assign nxt_pc = pc_ff + PDSA_PC_STEP;
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pc_ff <= PDSA_PC_RST;
        end else if (i_pc_load) begin
            pc_ff <= {i_pc_val[23:1], 1'b0};
        end else if (i_pc_adv) begin
            pc_ff <= nxt_pc;
        end
    end

    // control bits written by the core
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            win_en_ff <= 1'b0;
            win_pg_ff <= 8'h00;
            tbl_pg_ff <= 8'h00;
        end else begin
            if (i_cc_we) begin
                win_en_ff <= i_cc_wdata;
            end
            if (i_pg_we) begin
                win_pg_ff <= i_pg_wdata;
            end
            if (i_tp_we) begin
                tbl_pg_ff <= i_tp_wdata;
            end
        end
    end

    // program address: table, window or none
    always_comb begin
        o_prog_addr = PDSA_PC_RST;
        o_prog_rd = 1'b0;
        if (tbl_active) begin
            o_prog_addr = {tbl_pg_ff, i_tbl_ea};
            o_prog_rd = (i_tbl_kind != PDSA_TBL_NONE);
        end else if (win_hit) begin
            // window never reaches configuration space
            o_prog_addr = {1'b0, win_pg_ff, i_rd_ea[14:0]};
            o_prog_rd = 1'b1;
        end
    end

    pdsa_tbl_mux u_tbl_mux (
        .i_kind(i_tbl_kind),
        .i_byte(i_tbl_byte),
        .i_bsel(i_tbl_ea[0]),
        .i_pword(i_prog_rdata),
        .o_data(tbl_data)
    );

    // X read path; the ram sees word addresses, lsb picks the byte
    assign o_xmem_addr = {i_rd_ea[15:1], 1'b0};
    assign o_ymem_addr = {i_y_ea[15:1], 1'b0};
    assign o_ymem_rd = i_mac && i_y_rd;

    always_comb begin
        nxt_x_rdata = PDSA_ZERO;
        if (i_tbl_kind != PDSA_TBL_NONE) begin
            nxt_x_rdata = tbl_data;
        end else if (win_hit) begin
            nxt_x_rdata = i_prog_rdata[15:0];
        end else if (!in_ram(i_rd_ea)) begin
            nxt_x_rdata = PDSA_ZERO;
        end else if (i_mac && (i_rd_ptr != PDSA_PTR_X || in_y(i_rd_ea))) begin
            // multiply prefetch on X must use an X pointer outside Y
            nxt_x_rdata = PDSA_ZERO;
        end else if (i_rd_byte) begin
            nxt_x_rdata = i_rd_ea[0] ? {PDSA_ZB, i_xmem_rdata[15:8]}
                                     : {PDSA_ZB, i_xmem_rdata[7:0]};
        end else begin
            nxt_x_rdata = i_xmem_rdata;
        end
    end

    // registered read data
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            x_rdata_ff <= PDSA_ZERO;
            y_rdata_ff <= PDSA_ZERO;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= i_rd || (i_tbl_kind != PDSA_TBL_NONE);
            if (i_rd || (i_tbl_kind != PDSA_TBL_NONE)) begin
                x_rdata_ff <= nxt_x_rdata;
            end
            if (o_ymem_rd) begin
                // Y read with a non-Y pointer or outside Y returns zero
                y_rdata_ff <= (i_y_ptr == PDSA_PTR_Y && in_y(i_y_ea)) ?
                              i_ymem_rdata : PDSA_ZERO;
            end
        end
    end

    // extra cycles for window accesses
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            stall_ff <= PDSA_STALL_NONE;
        end else if (!win_hit) begin
            stall_ff <= PDSA_STALL_NONE;
        end else if (i_in_rpt) begin
            stall_ff <= i_rpt_edge ? PDSA_STALL_TWO : PDSA_STALL_NONE;
        end else begin
            stall_ff <= i_short_op ? PDSA_STALL_ONE : PDSA_STALL_TWO;
        end
    end

    // write address: modulo, or bit-reverse of the raw address instead for non write-back writes
    always_comb begin
        wr_ea_eff = i_wr_ea;
        if (i_mod_en) begin
            wr_ea_eff = modwrap(i_wr_ea, i_mod_start, i_mod_end);
        end
        if (i_brev_en && !i_wr_acc) begin
            wr_ea_eff = brev_add(i_wr_ea, i_brev_mod);
        end
    end

    // every write, write-back too, leaves on the X write bus
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            xwr_en_ff <= 1'b0;
            xwr_be_ff <= 2'h0;
            xwr_addr_ff <= PDSA_ZERO;
            xwr_data_ff <= PDSA_ZERO;
        end else begin
            xwr_en_ff <= i_wr || i_wr_acc;
            if (i_wr || i_wr_acc) begin
                xwr_addr_ff <= {wr_ea_eff[15:1], 1'b0};
                xwr_data_ff <= i_wr_byte ? {i_wr_data[7:0], i_wr_data[7:0]} : i_wr_data;
                xwr_be_ff <= !i_wr_byte ? 2'h3 : (wr_ea_eff[0] ? 2'h2 : 2'h1);
            end
        end
    end

    // program counter advance above user space is flagged
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            range_err_ff <= 1'b0;
        end else begin
            range_err_ff <= (i_pc_adv && nxt_pc > PDSA_USER_MAX);
        end
    end

    assign o_pc = pc_ff;
    assign o_window_en = win_en_ff;
    assign o_window_page = win_pg_ff;
    assign o_table_page = tbl_pg_ff;
    assign o_x_rdata = x_rdata_ff;
    assign o_y_rdata = y_rdata_ff;
    assign o_rd_valid = rd_valid_ff;
    assign o_stall = stall_ff;
    assign o_xwr_en = xwr_en_ff;
    assign o_xwr_be = xwr_be_ff;
    assign o_xwr_addr = xwr_addr_ff;
    assign o_xwr_data = xwr_data_ff;
    assign o_prog_range_err = range_err_ff;
endmodule

// file: tb/pdsa_core_asserts.sv
// Purpose: port-level checks of the program/data space access block
// Assumes: one clock, asynchronous active-low reset
// Notes: data byte reads and modulo writes are left to the bench
`timescale 1ns/10ps
module pdsa_core_chk
    import pdsa_pkg::*;
(
    input wire logic i_clk, // clock
    input wire logic i_arst_n, // reset, active low
    input wire logic i_pc_adv, // pc advance
    input wire logic i_pc_load, // pc load
    input wire logic [23:0] o_pc, // program counter
    input wire logic o_window_en, // window enable
    input wire logic [7:0] o_window_page, // window page
    input wire pdsa_tbl_t i_tbl_kind, // table read kind
    input wire logic i_tbl_wr, // table write
    input wire logic i_tbl_byte, // byte table read
    input wire logic [15:0] i_tbl_ea, // table address
    input wire logic i_rd, // read request
    input wire logic i_rd_byte, // byte read
    input wire logic [15:0] i_rd_ea, // read address
    input wire pdsa_ptr_t i_rd_ptr, // read pointer class
    input wire logic i_mac, // multiply class
    input wire logic i_short_op, // short stall class
    input wire logic i_in_rpt, // inside repeat
    input wire logic i_rpt_edge, // repeat edge
    input wire logic [23:0] i_prog_rdata, // program word
    input wire logic [23:0] o_prog_addr, // program address
    input wire logic o_prog_rd, // program read
    input wire logic [15:0] o_x_rdata, // X read data
    input wire logic o_rd_valid, // read valid
    input wire logic [1:0] o_stall // extra cycles
);
    logic [23:0] pw_ff;
    logic win;
    // program word of the previous cycle, since read data lands one edge later
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pw_ff <= 24'h000000;
        end else begin
            pw_ff <= i_prog_rdata;
        end
    end
    // a mapped window read; table activity suspends it
    assign win = i_rd && i_rd_ea[15] && o_window_en && !i_tbl_wr && i_tbl_kind == PDSA_TBL_NONE;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    a_pc_step: assert property (i_pc_adv && !i_pc_load |=> o_pc == $past(o_pc) + PDSA_PC_STEP)
        else $error("pc did not step by two");
    a_win_addr: assert property (win |-> o_prog_rd && o_prog_addr == {1'b0, o_window_page, i_rd_ea[14:0]})
        else $error("window address wrong");
    a_win_data: assert property (win && !i_rd_byte |=> o_rd_valid && o_x_rdata == pw_ff[15:0])
        else $error("window data wrong");
    a_win_block: assert property (i_rd && i_rd_ea[15] && (!o_window_en || i_tbl_wr)
        && i_tbl_kind == PDSA_TBL_NONE |-> !o_prog_rd)
        else $error("window mapped while disabled");
    a_tbl_low: assert property (i_tbl_kind == PDSA_TBL_LOW && !i_tbl_byte |=> o_x_rdata == pw_ff[15:0])
        else $error("low table word wrong");
    a_tbl_high: assert property (i_tbl_kind == PDSA_TBL_HIGH && !i_tbl_byte
        |=> o_x_rdata == {8'h00, pw_ff[23:16]})
        else $error("high table word wrong");
    a_tbl_hbyte: assert property (i_tbl_kind == PDSA_TBL_HIGH && i_tbl_byte && i_tbl_ea[0]
        |=> o_x_rdata == 16'h0000)
        else $error("high odd byte not zero");
    a_stall_out: assert property (win && !i_in_rpt
        |=> o_stall == ($past(i_short_op) ? PDSA_STALL_ONE : PDSA_STALL_TWO))
        else $error("stall outside repeat wrong");
    a_stall_rpt: assert property (win && i_in_rpt
        |=> o_stall == ($past(i_rpt_edge) ? PDSA_STALL_TWO : PDSA_STALL_NONE))
        else $error("stall inside repeat wrong");
    a_mac_zero: assert property (i_rd && i_mac && i_rd_ptr == PDSA_PTR_Y && !i_rd_ea[15]
        |=> o_x_rdata == 16'h0000)
        else $error("wrong-pointer read not zero");
    c_win: cover property (win && i_in_rpt);
    c_tbl: cover property (i_tbl_kind == PDSA_TBL_HIGH && i_tbl_byte);
    c_mac: cover property (i_rd && i_mac);
endmodule

bind pdsa_core pdsa_core_chk u_chk (.i_clk, .i_arst_n, .i_pc_adv, .i_pc_load, .o_pc,
    .o_window_en, .o_window_page, .i_tbl_kind, .i_tbl_wr, .i_tbl_byte, .i_tbl_ea, .i_rd,
    .i_rd_byte, .i_rd_ea, .i_rd_ptr, .i_mac, .i_short_op, .i_in_rpt, .i_rpt_edge,
    .i_prog_rdata, .o_prog_addr, .o_prog_rd, .o_x_rdata, .o_rd_valid, .o_stall);

// file: tb/pdsa_mem_model.sv
// Purpose: program, X and Y memories behind the access block
// Assumes: memories answer in the same cycle
// Notes: contents are a fixed function of address; idle lines invert
`timescale 1ns/10ps
module pdsa_mem_model (
    input wire logic [23:0] i_prog_addr, // program address
    input wire logic i_prog_rd, // program read
    output logic [23:0] o_prog_rdata, // program word
    input wire logic [15:0] i_xmem_addr, // X address
    output logic [15:0] o_xmem_rdata, // X word
    input wire logic [15:0] i_ymem_addr, // Y address
    input wire logic i_ymem_rd, // Y read
    output logic [15:0] o_ymem_rdata // Y word
);
    function automatic logic [23:0] pw(input logic [23:0] a);
        return {a[23:16] ^ a[7:0], a[15:0] ^ {a[23:16], 8'h5a}};
    endfunction
    // unread lines show the inverse so a stale capture never matches
    assign o_prog_rdata = i_prog_rd ? pw(i_prog_addr) : ~pw(i_prog_addr);
    assign o_xmem_rdata = i_xmem_addr ^ 16'h5a5a;
    assign o_ymem_rdata = i_ymem_rd ? i_ymem_addr ^ 16'hc3c3 : ~(i_ymem_addr ^ 16'hc3c3);
endmodule

// file: tb/pdsa_core_tb.sv
// Purpose: self-checking bench for the program/data space access block
// Assumes: inputs change on the falling edge
// Notes: read results go through a queue checked by a monitor
`timescale 1ns/10ps
module pdsa_core_tb;
    import pdsa_pkg::*;
    logic i_clk = 1'b0;
    logic i_arst_n, i_pc_adv, i_pc_load, i_cc_we, i_cc_wdata, i_pg_we, i_tp_we, i_tbl_wr;
    logic i_tbl_byte, i_rd, i_rd_byte, i_mac, i_y_rd, i_short_op, i_in_rpt, i_rpt_edge;
    logic i_wr, i_wr_acc, i_wr_byte, i_mod_en, i_brev_en, o_window_en, o_prog_rd, o_ymem_rd;
    logic o_xwr_en, o_rd_valid, o_prog_range_err;
    logic [23:0] i_pc_val, o_pc, o_prog_addr, i_prog_rdata, w;
    logic [7:0] i_pg_wdata, i_tp_wdata, o_window_page, o_table_page, tp, pg;
    logic [15:0] i_tbl_ea, i_rd_ea, i_y_ea, i_wr_ea, i_wr_data, i_mod_start, i_mod_end;
    logic [15:0] i_brev_mod, o_xmem_addr, i_xmem_rdata, o_ymem_addr, i_ymem_rdata, ea, ya;
    logic [15:0] o_xwr_addr, o_xwr_data, o_x_rdata, o_y_rdata;
    logic [1:0] o_xwr_be, o_stall;
    pdsa_tbl_t i_tbl_kind;
    pdsa_ptr_t i_rd_ptr, i_y_ptr;
    logic [15:0] q[$];
    logic [31:0] seed = 32'h11cba1e0;
    logic [31:0] r;
    int errors = 0;
    int n_tests = 0;
    pdsa_core dut (.i_clk, .i_arst_n, .i_pc_adv, .i_pc_load, .i_pc_val, .o_pc, .i_cc_we,
        .i_cc_wdata, .i_pg_we, .i_pg_wdata, .i_tp_we, .i_tp_wdata, .o_window_en, .o_window_page,
        .o_table_page, .i_tbl_kind, .i_tbl_wr, .i_tbl_byte, .i_tbl_ea, .i_rd, .i_rd_byte,
        .i_rd_ea, .i_rd_ptr, .i_mac, .i_y_rd, .i_y_ea, .i_y_ptr, .i_short_op, .i_in_rpt,
        .i_rpt_edge, .i_wr, .i_wr_acc, .i_wr_byte, .i_wr_ea, .i_wr_data, .i_mod_en,
        .i_mod_start, .i_mod_end, .i_brev_en, .i_brev_mod, .o_prog_addr, .o_prog_rd,
        .i_prog_rdata, .o_xmem_addr, .i_xmem_rdata, .o_ymem_addr, .o_ymem_rd, .i_ymem_rdata,
        .o_xwr_en, .o_xwr_be, .o_xwr_addr, .o_xwr_data, .o_x_rdata, .o_y_rdata, .o_rd_valid,
        .o_stall, .o_prog_range_err);
    pdsa_mem_model mem (.i_prog_addr(o_prog_addr), .i_prog_rd(o_prog_rd),
        .o_prog_rdata(i_prog_rdata), .i_xmem_addr(o_xmem_addr), .o_xmem_rdata(i_xmem_rdata),
        .i_ymem_addr(o_ymem_addr), .i_ymem_rd(o_ymem_rd), .o_ymem_rdata(i_ymem_rdata));
    always #10 i_clk = ~i_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [23:0] pw(input logic [23:0] a);
        return {a[23:16] ^ a[7:0], a[15:0] ^ {a[23:16], 8'h5a}};
    endfunction
    // expected table-read formatting of a program word
    function automatic logic [15:0] tf(input int k, input logic b, input logic s,
        input logic [23:0] p);
        if (k == 1) begin
            return b ? {8'h00, s ? p[15:8] : p[7:0]} : p[15:0];
        end
        return (b && s) ? 16'h0000 : {8'h00, p[23:16]};
    endfunction
    task automatic chk(input string nm, input logic [39:0] s, input logic [39:0] e);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // X read with a Y-pointer prefetch from ya alongside multiply-class reads
    task automatic op(input logic [15:0] a, input pdsa_ptr_t p, input logic m,
        input logic [15:0] e);
        @(negedge i_clk);
        i_rd = 1'b1;
        i_rd_ea = a;
        i_rd_ptr = p;
        {i_mac, i_y_rd, i_y_ea} = {m, m, ya};
        i_y_ptr = PDSA_PTR_Y;
        q.push_back(e);
        @(negedge i_clk);
        {i_rd, i_mac, i_y_rd} = 3'h0;
    endtask
    task automatic tr(input int k, input logic b, input logic [15:0] a);
        @(negedge i_clk);
        i_tbl_kind = pdsa_tbl_t'(k);
        {i_tbl_byte, i_tbl_ea} = {b, a};
        q.push_back(tf(k, b, a[0], pw({tp, a})));
        #1 chk("tbl_addr", 40'(o_prog_addr), 40'({tp, a}));
        @(negedge i_clk);
        i_tbl_kind = PDSA_TBL_NONE;
    endtask
    task automatic wr(input logic acc, input logic [15:0] a, input logic [15:0] e);
        @(negedge i_clk);
        r = rnd();
        {i_wr, i_wr_acc, i_wr_ea, i_wr_data} = {!acc, acc, a, r[15:0]};
        @(negedge i_clk);
        {i_wr, i_wr_acc} = 2'h0;
        chk("xwr", 40'({o_xwr_en, o_xwr_be, o_xwr_addr, o_xwr_data}),
            40'({3'h7, e, r[15:0]}));
    endtask
    // oldest expectation is matched against each read result
    always @(negedge i_clk) begin
        if (o_rd_valid === 1'b1) begin
            if (q.size() == 0) begin
                chk("rd_valid", 40'h1, 40'h0);
            end else begin
                chk("x_rdata", 40'(o_x_rdata), 40'(q.pop_front()));
            end
        end
    end
    initial begin
        repeat (4000) @(posedge i_clk);
        errors++;
        end_of_test();
    end
    initial begin
        {i_arst_n, i_pc_adv, i_pc_load, i_cc_we, i_cc_wdata, i_pg_we, i_tp_we, i_tbl_wr} = 8'h0;
        {i_tbl_byte, i_rd, i_rd_byte, i_mac, i_y_rd, i_short_op, i_in_rpt, i_rpt_edge} = 8'h0;
        {i_wr, i_wr_acc, i_wr_byte, i_mod_en, i_brev_en} = 5'h0;
        {i_pc_val, i_pg_wdata, i_tp_wdata, i_tbl_ea, i_rd_ea, i_y_ea} = 88'h0;
        i_tbl_kind = PDSA_TBL_NONE;
        i_rd_ptr = PDSA_PTR_OTHER;
        i_y_ptr = PDSA_PTR_OTHER;
        ya = 16'h0090;
        r = rnd();
        {i_mod_start, i_mod_end, i_brev_mod, i_wr_ea, i_wr_data} = {r, r[15:0], 32'h0};
        repeat (6) @(posedge i_clk);
        @(negedge i_clk);
        i_arst_n = 1'b1;
        chk("rst", 40'({o_pc, o_window_en}), 40'h0);
        op(16'h8004, PDSA_PTR_OTHER, 1'b0, 16'h0000);
        i_pc_adv = 1'b1;
        repeat (5) @(negedge i_clk);
        chk("pc_adv", 40'(o_pc), 40'h00000a);
        r = rnd();
        {i_pc_load, i_pc_val} = {1'b1, r[23:0]};
        @(negedge i_clk);
        i_pc_load = 1'b0;
        @(negedge i_clk);
        i_pc_adv = 1'b0;
        w = {r[23:1], 1'b0} + PDSA_PC_STEP;
        chk("pc_load", 40'(o_pc), 40'(w));
        chk("range_err", 40'(o_prog_range_err), 40'(w > PDSA_USER_MAX));
        r = rnd();
        {tp, pg} = r[15:0];
        {i_tp_we, i_tp_wdata, i_pg_we, i_pg_wdata} = {1'b1, tp, 1'b1, pg};
        {i_cc_we, i_cc_wdata} = 2'h3;
        @(negedge i_clk);
        {i_tp_we, i_pg_we, i_cc_we} = 3'h0;
        chk("pages", 40'({o_table_page, o_window_page, o_window_en}), 40'({tp, pg, 1'b1}));
        for (int k = 1; k < 3; k++) begin
            for (int s = 0; s < 4; s++) begin
                r = rnd();
                tr(k, s[1], {r[15:1], s[0]});
            end
        end
        // window reads with random stall qualifier mixes
        repeat (16) begin
            r = rnd();
            {i_short_op, i_in_rpt, i_rpt_edge} = r[18:16];
            ea = {1'b1, r[14:1], 1'b0};
            w = pw({1'b0, pg, ea[14:0]});
            op(ea, PDSA_PTR_OTHER, 1'b0, w[15:0]);
        end
        i_tbl_wr = 1'b1;
        op(16'h8010, PDSA_PTR_OTHER, 1'b0, 16'h0000);
        i_tbl_wr = 1'b0;
        op(16'h0010, PDSA_PTR_OTHER, 1'b0, 16'h0010 ^ 16'h5a5a);
        op(16'h0090, PDSA_PTR_OTHER, 1'b0, 16'h0090 ^ 16'h5a5a);
        op(16'h0090, PDSA_PTR_X, 1'b1, 16'h0000);
        op(16'h0010, PDSA_PTR_X, 1'b1, 16'h0010 ^ 16'h5a5a);
        chk("y_rdata", 40'(o_y_rdata), 40'(16'h0090 ^ 16'hc3c3));
        // Y pointer aimed at X space on both paths
        ya = 16'h0020;
        op(16'h0020, PDSA_PTR_Y, 1'b1, 16'h0000);
        chk("y_zero", 40'(o_y_rdata), 40'h0);
        // odd byte lands in the low byte
        i_rd_byte = 1'b1;
        op(16'h0013, PDSA_PTR_OTHER, 1'b0, 16'h005a);
        i_rd_byte = 1'b0;
        op(16'h4000, PDSA_PTR_OTHER, 1'b0, 16'h0000);
        wr(1'b0, 16'h0020, 16'h0020);
        {i_mod_en, i_mod_start, i_mod_end} = {1'b1, 16'h0040, 16'h005e};
        wr(1'b0, 16'h0060, 16'h0040);
        {i_mod_en, i_brev_en, i_brev_mod} = {1'b0, 1'b1, 16'h0008};
        wr(1'b0, 16'h0008, 16'h0004);
        wr(1'b1, 16'h0090, 16'h0090);
        repeat (3) @(negedge i_clk);
        chk("q_left", 40'(q.size()), 40'h0);
        end_of_test();
    end
endmodule
